// ---- core/pwmps_pkg.sv ----
package pwmps_pkg;
  // channel counts
  localparam int NUM_CH = 10;
  localparam int ALT_CH = 8;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DATA = 8'h04;
  localparam logic [7:0] OFF_EN = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  // control register fields
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_LOC_LSB = 4;
  // local select codes, 1x is delay
  localparam logic [1:0] LOC_DUTY = 2'h0;
  localparam logic [1:0] LOC_CFG = 2'h1;
  // channel configuration fields
  localparam int CFG_W = 10;
  localparam int CFG_RES_LSB = 0;
  localparam int CFG_PS_LSB = 4;
  localparam int CFG_INV_BIT = 6;
  localparam int CFG_ALT_BIT = 7;
  localparam int CFG_CLK_LSB = 8;
  // clock source codes, 2'h3 also external
  localparam logic [1:0] CLK_CORE = 2'h0;
  localparam logic [1:0] CLK_PERIPH = 2'h1;
  localparam logic [1:0] CLK_EXT = 2'h2;
  // resolution and slot arithmetic
  localparam logic [4:0] RES_BASE = 5'h07;
  localparam logic [4:0] RES_MAX = 5'h10;
  localparam logic [3:0] RES_CODE_MAX = 4'h9;
  localparam logic [4:0] PS_REF = 5'h0a;
  localparam logic [3:0] SLOT_EXP_MAX = 4'h9;
  // reset values
  localparam logic [15:0] DUTY_RST = 16'h0000;
  localparam logic [9:0] CFG_RST = 10'h000;
  localparam logic [15:0] DLY_RST = 16'h0000;
endpackage

// ---- core/pwmps_top.sv ----
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - ten channels, sixteen bits, separately enabled
// - three local registers per channel
// - data port writes selected channel's register
// - local select: duty, config, delay
// - channel select advances after data access
// - channel clock: core, peripheral or external
// - frame lasts two-to-the-N channel clocks
// - duty compare uses low N bits
// - output high until count equals duty
// - resolution seven to sixteen, invertible
// - channels 0-7 may use alternate pin
// - resolution codes above nine give sixteen
// - two-bit spreading option picks slot count
// - slots two-to-(N-10+option), at least one
// - frame split into equal slots
// - delta-sigma spreads remainder over slots
// - eight-slot extra counts follow fixed order
// - output rate follows channel clock source
module pwmps_top (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // external channel clock pin
  input wire logic i_ext_clk,
  // channel outputs
  output logic [pwmps_pkg::NUM_CH-1:0] o_pwm_main,
  output logic [pwmps_pkg::ALT_CH-1:0] o_pwm_alt
);
  localparam int NC = pwmps_pkg::NUM_CH;
  localparam int NA = pwmps_pkg::ALT_CH;
  localparam int CW = pwmps_pkg::CFG_W;

  //////////////////////////////////////////////////////////////////////////////
  // register state
  logic [3:0] sel;
  logic [1:0] loc;
  logic [NC-1:0] ch_en;
  logic [15:0] duty [NC];
  logic [CW-1:0] cfg [NC];
  logic [15:0] dly [NC];
  // channel state
  logic [15:0] pos [NC];
  logic [9:0] acc [NC];
  logic [15:0] dact [NC];
  wire [NC-1:0] restart;
  wire [NC-1:0] pin_main;
  wire [NA-1:0] pin_alt;

  //////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire setup = i_psel & ~i_penable;
  wire done = i_psel & i_penable & o_pready;
  wire wr = done & i_pwrite;
  wire hit_ctrl = i_paddr == pwmps_pkg::OFF_CTRL;
  wire hit_data = i_paddr == pwmps_pkg::OFF_DATA;
  wire hit_en = i_paddr == pwmps_pkg::OFF_EN;
  wire hit_stat = i_paddr == pwmps_pkg::OFF_STAT;
  wire mapped = hit_ctrl | hit_data | hit_en | hit_stat;
  wire sel_ok = sel < 4'(NC);
  wire [3:0] sel_ix = sel_ok ? sel : 4'h0;
  wire [3:0] sel_inc = (sel >= 4'(NC - 1)) ? 4'h0 : sel + 4'h1;
  // local register read selection
  wire [15:0] loc_rd = !sel_ok ? 16'h0000 :
                       (loc == pwmps_pkg::LOC_DUTY) ? duty[sel_ix] :
                       (loc == pwmps_pkg::LOC_CFG) ? {6'h00, cfg[sel_ix]} :
                       dly[sel_ix];
  wire [31:0] rd_mux = hit_ctrl ? {26'h0, loc, sel} :
                       hit_data ? {16'h0000, loc_rd} :
                       hit_en ? {22'h0, ch_en} :
                       hit_stat ? {14'h0, o_pwm_alt, o_pwm_main} : 32'h0;

  // no wait state: ready rises in the first access-phase cycle
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= setup;
      if (setup) begin
        o_prdata <= i_pwrite ? 32'h0 : rd_mux;
        o_pslverr <= ~mapped;
      end
    end
  end

  // control, pointer and enables
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sel <= 4'h0;
      loc <= 2'h0;
      ch_en <= '0;
    end else begin
      if (wr & hit_ctrl) begin
        sel <= i_pwdata[pwmps_pkg::CTRL_SEL_LSB +: 4];
        loc <= i_pwdata[pwmps_pkg::CTRL_LOC_LSB +: 2];
      end else if (done & hit_data) begin
        sel <= sel_inc;
      end
      if (wr & hit_en) begin
        ch_en <= i_pwdata[NC-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // channel clock enables
  logic ext_s1, ext_s2, ext_s3, per_tog;
  wire ext_rise = ext_s2 & ~ext_s3;
  wire [3:0] src_tick = {ext_rise, ext_rise, per_tog, 1'b1};

  // pin sync and half-rate peripheral enable
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
      per_tog <= 1'b0;
    end else begin
      ext_s1 <= i_ext_clk;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      per_tog <= ~per_tog;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // channels
  for (genvar c = 0; c < NC; c++) begin : g_ch
    wire wr_me = wr & hit_data & (sel == 4'(c));
    wire [3:0] rc = cfg[c][pwmps_pkg::CFG_RES_LSB +: 4];
    wire [1:0] ps = cfg[c][pwmps_pkg::CFG_PS_LSB +: 2];
    wire [1:0] cs = cfg[c][pwmps_pkg::CFG_CLK_LSB +: 2];
    wire inv = cfg[c][pwmps_pkg::CFG_INV_BIT];
    // resolution and slot exponent
    wire [4:0] n = (rc > pwmps_pkg::RES_CODE_MAX) ? pwmps_pkg::RES_MAX :
                   pwmps_pkg::RES_BASE + {1'b0, rc};
    wire [4:0] ne = n + {3'h0, ps};
    wire [3:0] k = (ne > pwmps_pkg::PS_REF) ?
                   4'(ne - pwmps_pkg::PS_REF) : 4'h0;
    wire [4:0] sl = n - {1'b0, k};
    // masks for frame, slot and slot count
    wire [15:0] fmask = ~(16'hffff << n);
    wire [15:0] smask = ~(16'hffff << sl);
    wire [9:0] rmask = ~(10'h3ff << k);
    wire [10:0] snum = {1'b0, rmask} + 11'h001;
    // quotient and remainder of the duty
    wire [15:0] dm = dact[c] & fmask;
    wire [15:0] q = dm >> k;
    wire [9:0] r = dm[9:0] & rmask;
    // current slot takes an extra count when accumulator plus remainder reaches the slot count
    wire [10:0] sum = {1'b0, acc[c]} + {1'b0, r};
    wire over = sum >= snum;
    // slot position and compare
    wire [15:0] spos = pos[c] & smask;
    wire [16:0] hc = {1'b0, q} + {16'h0000, over};
    wire hi = {1'b0, spos} < hc;
    wire tick = src_tick[cs];
    wire fend = pos[c] == fmask;
    wire send = spos == smask;
    assign restart[c] = ~ch_en[c] | (tick & fend);
    assign pin_main[c] = ch_en[c] & (hi ^ inv);

    // local registers of this channel
    always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
        duty[c] <= pwmps_pkg::DUTY_RST;
        cfg[c] <= pwmps_pkg::CFG_RST;
        dly[c] <= pwmps_pkg::DLY_RST;
      end else if (wr_me) begin
        if (loc == pwmps_pkg::LOC_DUTY) begin
          duty[c] <= i_pwdata[15:0];
        end else if (loc == pwmps_pkg::LOC_CFG) begin
          cfg[c] <= i_pwdata[CW-1:0];
        end else begin
          dly[c] <= i_pwdata[15:0];
        end
      end
    end

    // frame counter and dither accumulator
    always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
        pos[c] <= 16'h0000;
        acc[c] <= 10'h000;
        dact[c] <= pwmps_pkg::DUTY_RST;
      end else if (restart[c]) begin
        pos[c] <= 16'h0000;
        acc[c] <= 10'h000;
        dact[c] <= duty[c];
      end else if (tick) begin
        pos[c] <= pos[c] + 16'h0001;
        if (send) begin
          acc[c] <= over ? 10'(sum - snum) : sum[9:0];
        end
      end
    end

    // pin routing for channels with a second pin
    if (c < NA) begin : g_alt
      wire alt = cfg[c][pwmps_pkg::CFG_ALT_BIT];
      assign pin_alt[c] = pin_main[c] & alt;
    end
  end

  // registered outputs
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pwm_main <= '0;
      o_pwm_alt <= '0;
    end else begin
      o_pwm_main <= pin_main & ~{2'h0, pin_alt};
      o_pwm_alt <= pin_alt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  property p_sel_step;
    done && hit_data |=> sel == $past(sel_inc);
  endproperty
  a_sel_step: assert property (p_sel_step)
    else $error("channel select did not advance");

  property p_duty_wr;
    wr && hit_data && loc == pwmps_pkg::LOC_DUTY && sel == 4'h0
      |=> duty[0] == 16'($past(i_pwdata));
  endproperty
  a_duty_wr: assert property (p_duty_wr)
    else $error("duty write missed");

  property p_cfg_wr;
    wr && hit_data && loc == pwmps_pkg::LOC_CFG && sel == 4'h1
      |=> cfg[1] == 10'($past(i_pwdata));
  endproperty
  a_cfg_wr: assert property (p_cfg_wr)
    else $error("config write missed");

  property p_dly_wr;
    wr && hit_data && loc[1] && sel == 4'h2
      |=> dly[2] == 16'($past(i_pwdata)) && duty[2] == $past(duty[2]);
  endproperty
  a_dly_wr: assert property (p_dly_wr)
    else $error("delay write missed");

  property p_off_low;
    !ch_en[0] [*2] |-> !o_pwm_main[0] && !o_pwm_alt[0];
  endproperty
  a_off_low: assert property (p_off_low)
    else $error("disabled channel drives high");

  property p_count;
    ch_en[0] && !restart[0] && g_ch[0].tick
      |=> pos[0] == $past(pos[0]) + 16'h0001;
  endproperty
  a_count: assert property (p_count)
    else $error("frame count did not step");

  sequence s_fend;
    ch_en[0] && g_ch[0].tick && g_ch[0].fend;
  endsequence
  sequence s_fstart;
    ch_en[0] && !g_ch[0].inv && g_ch[0].q != 16'h0000 && !cfg[0][7];
  endsequence
  property p_start_high;
    s_fend ##1 s_fstart |=> o_pwm_main[0];
  endproperty
  a_start_high: assert property (p_start_high)
    else $error("frame did not start high");

  property p_res;
    g_ch[0].rc > pwmps_pkg::RES_CODE_MAX |-> g_ch[0].n == pwmps_pkg::RES_MAX;
  endproperty
  a_res: assert property (p_res)
    else $error("resolution code not clamped");

  property p_acc;
    {1'b0, acc[0]} < g_ch[0].snum && g_ch[0].k <= pwmps_pkg::SLOT_EXP_MAX;
  endproperty
  a_acc: assert property (p_acc)
    else $error("dither state out of range");

  property p_latch;
    dact[0] != $past(dact[0]) |-> $past(restart[0]);
  endproperty
  a_latch: assert property (p_latch)
    else $error("duty changed mid-frame");

  property p_alt;
    ch_en[0] && cfg[0][7] |=> !o_pwm_main[0];
  endproperty
  a_alt: assert property (p_alt)
    else $error("main pin active while routed");
endmodule

// ---- test/pwmps_pin_mon.sv ----
`timescale 1ns/100ps
module pwmps_pin_mon (
  // sampling clock
  input wire logic i_clk,
  // watched output pin
  input wire logic i_pin,
  // last measured high run and rise spacing
  output int o_high,
  output int o_period
);
  logic prev = 1'b0;
  int hi = 0;
  int per = 0;
  wire rise = i_pin && !prev;
  // load stage: counts high cycles and rise-to-rise spacing
  always @(posedge i_clk) begin
    prev <= i_pin;
    per <= rise ? 1 : per + 1;
    hi <= rise ? 1 : hi + int'(i_pin);
    if (rise) o_period <= per;
    if (!i_pin && prev) o_high <= hi;
  end
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [9:0] pwm_main;
  logic [7:0] pwm_alt;
  logic [31:0] rd;
  logic err;
  int fails = 0;
  int cmp_count = 0;
  int m_hi;
  int m_per;
  int a_hi;
  int a_per;
  logic [1:0] ext_div = 2'h0;
  ////////////////////////////////////////////////////////////////////////////////
  // clock, design and pin monitors
  always #5 clk = ~clk;
  // external channel clock at a quarter of the core rate
  always @(posedge clk) ext_div <= ext_div + 2'h1;
  pwmps_top dut (.i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_ext_clk(ext_div[1]), .o_pwm_main(pwm_main),
    .o_pwm_alt(pwm_alt));
  pwmps_pin_mon mon_main (.i_clk(clk), .i_pin(pwm_main[0]), .o_high(m_hi), .o_period(m_per));
  pwmps_pin_mon mon_alt (.i_clk(clk), .i_pin(pwm_alt[0]), .o_high(a_hi), .o_period(a_per));
  ////////////////////////////////////////////////////////////////////////////////
  // verdict and shared helpers
  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      $display("[ERR] %0t %s got %0h want %0h", $time, what, got, exp);
      fails++;
    end
  endtask
  // one apb transfer, held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      $display("[ERR] %0t no pready", $time);
      fails++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // program channel 0 config and duty, enable it, let frames settle
  task chan(input logic [9:0] cfg, input logic [15:0] duty);
    apb(1'b1, pwmps_pkg::OFF_CTRL, 32'h00000010);
    apb(1'b1, pwmps_pkg::OFF_DATA, {22'h000000, cfg});
    apb(1'b1, pwmps_pkg::OFF_CTRL, 32'h00000000);
    apb(1'b1, pwmps_pkg::OFF_DATA, {16'h0000, duty});
    apb(1'b1, pwmps_pkg::OFF_EN, 32'h00000001);
    repeat (2500) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task t_regs;
    apb(1'b0, 8'h10, 32'h00000000);
    chk({31'h0, err}, 32'h00000001, "unmapped error");
    chk(rd, 32'h00000000, "unmapped data");
    apb(1'b1, pwmps_pkg::OFF_CTRL, 32'h00000029);
    apb(1'b1, pwmps_pkg::OFF_DATA, 32'h00001234);
    apb(1'b0, pwmps_pkg::OFF_CTRL, 32'h00000000);
    chk(rd, 32'h00000020, "select wrap");
    apb(1'b1, pwmps_pkg::OFF_CTRL, 32'h00000039);
    apb(1'b0, pwmps_pkg::OFF_DATA, 32'h00000000);
    chk(rd, 32'h00001234, "delay via 11");
    apb(1'b0, pwmps_pkg::OFF_CTRL, 32'h00000000);
    chk(rd, 32'h00000030, "select after read");
    apb(1'b1, pwmps_pkg::OFF_CTRL, 32'h00000010);
    apb(1'b1, pwmps_pkg::OFF_DATA, 32'h0000000f);
    apb(1'b1, pwmps_pkg::OFF_DATA, 32'h000002a5);
    apb(1'b1, pwmps_pkg::OFF_CTRL, 32'h00000022);
    apb(1'b1, pwmps_pkg::OFF_DATA, 32'h0000beef);
    apb(1'b1, pwmps_pkg::OFF_CTRL, 32'h00000011);
    apb(1'b0, pwmps_pkg::OFF_DATA, 32'h00000000);
    chk(rd, 32'h000002a5, "config readback");
    apb(1'b1, pwmps_pkg::OFF_CTRL, 32'h00000022);
    apb(1'b0, pwmps_pkg::OFF_DATA, 32'h00000000);
    chk(rd, 32'h0000beef, "delay readback");
    $display("test regs done");
  endtask
  task t_pwm(input logic [9:0] cfg, input logic [15:0] duty, input int hi, input int per);
    chan(cfg, duty);
    chk(32'(m_hi), 32'(hi), "high run");
    chk(32'(m_per), 32'(per), "period");
    $display("test pwm cfg %0h done", cfg);
  endtask
  task t_alt;
    chan(10'h080, 16'h0003);
    chk(32'(a_hi), 32'd3, "alt high");
    chk({31'h0, pwm_main[0]}, 32'h00000000, "main idle");
    $display("test alt done");
  endtask
  // ten-bit, eight slots, duty 131: extra counts in slots 3, 6 and 8
  task t_spread;
    int n;
    int run;
    int tot;
    int runs;
    logic prev;
    logic fall;
    logic ok;
    logic [7:0] pat;
    chan(10'h033, 16'h0083);
    n = 0;
    prev = 1'b0;
    fall = 1'b0;
    // align to the end of a high run
    do begin
      @(negedge clk);
      n++;
      fall = prev & ~pwm_main[0];
      prev = pwm_main[0];
    end while (!fall && n < 3000);
    if (!fall) begin
      $display("[ERR] %0t no falling edge", $time);
      fails++;
      test_done();
    end
    run = 0;
    tot = 0;
    runs = 0;
    pat = 8'h00;
    prev = 1'b0;
    // one full frame of samples, eight complete runs
    repeat (1024) begin
      @(negedge clk);
      if (pwm_main[0]) begin
        run++;
        tot++;
      end else if (prev) begin
        runs++;
        pat = {pat[6:0], run == 17};
        run = 0;
      end
      prev = pwm_main[0];
    end
    ok = 1'b0;
    for (int j = 0; j < 8; j++) begin
      ok = ok | (pat == 8'h25);
      pat = {pat[6:0], pat[7]};
    end
    chk(32'(tot), 32'd131, "spread total");
    chk(32'(runs), 32'd8, "slot count");
    chk({31'h0, ok}, 32'h00000001, "extra slot order");
    $display("test spread done");
  endtask
  task t_off;
    apb(1'b1, pwmps_pkg::OFF_EN, 32'h00000000);
    repeat (4) @(posedge clk);
    chk({22'h0, pwm_main}, 32'h00000000, "disabled low");
    chk({24'h0, pwm_alt}, 32'h00000000, "alt disabled low");
    apb(1'b0, pwmps_pkg::OFF_STAT, 32'h00000000);
    chk(rd, 32'h00000000, "status idle");
    $display("test off done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_pwm(10'h000, 16'h0183, 3, 128);
    t_pwm(10'h040, 16'h0003, 125, 128);
    t_pwm(10'h100, 16'h0003, 6, 256);
    t_pwm(10'h200, 16'h0003, 12, 512);
    t_pwm(10'h300, 16'h0003, 12, 512);
    t_pwm(10'h001, 16'h0010, 16, 256);
    t_pwm(10'h033, 16'h0080, 16, 128);
    t_spread();
    t_alt();
    t_off();
    test_done();
  end
endmodule
